// >>> fal_defines.svh
// Constants for the first-address capture link: timing figures and counts.
// Assumes a 40 MHz reference clock; included by its bare name.
`ifndef FAL_DEFINES_SVH
`define FAL_DEFINES_SVH
`define FAL_CLK_MHZ 40
`define FAL_CLK_PERIOD_NS 25
`define FAL_ADDR_W 23
`define FAL_DATA_W 16
`define FAL_MEM_AW 8
`define FAL_FIRST_CAPTURE_EDGE 2
`define FAL_LAST_SEQ_EDGE 3
`define FAL_CLK_GAP_NS 600
`define FAL_CLK_GAP_CYC ((`FAL_CLK_GAP_NS * `FAL_CLK_MHZ + 999) / 1000)
`define FAL_RWL_NS 1000
`define FAL_RWL_CYC ((`FAL_RWL_NS * `FAL_CLK_MHZ + 999) / 1000)
`define FAL_FREE_SETUP_US 200
`define FAL_FREE_SETUP_CYC (`FAL_FREE_SETUP_US * `FAL_CLK_MHZ)
`define FAL_PROG_MAX_US 180
`define FAL_PROG_CYC (`FAL_PROG_MAX_US * `FAL_CLK_MHZ)
`define FAL_ERASE_PARAM_MAX_MS 2500
`define FAL_ERASE_PARAM_CYC (`FAL_ERASE_PARAM_MAX_MS * `FAL_CLK_MHZ * 1000)
`define FAL_ERASE_MAIN_MAX_MS 4000
`define FAL_ERASE_MAIN_CYC (`FAL_ERASE_MAIN_MAX_MS * `FAL_CLK_MHZ * 1000)
`define FAL_TIMER_W 28
`endif

// >>> fal_device.sv
// Device end: handshake release, first-address capture, burst read,
// and timed program and erase of a small word array.
// Assumes the flash clock pin is sampled as a plain input on ref_clk.
//
// Function
// - Capture sequence spans four flash clock cycles.
// - Latch address on third rising edge after release.
// - Master holds strobe high, reset high, enable low.
// - Handshake low aborts sequence, sets config bit four.
// - At power-on start on later of release, enable-fall.
// - After power-on only handshake rise starts sequence.
// - Master waits 600 ns after release before clocking.
// - Master waits 600 ns after enable falls.
// - Free clock: address, enable valid 200 us early.
// - Free clock: hold address 200 us past edge four.
// - Master uses generous margins around counted edges.
// - Master resets device after I/O supply drop.
// - Program and erase finish within maximum times.
// - Handshake held low during reset, released after delay.
`timescale 1ns/1ps
`include "fal_defines.svh"
module fal_device #(
   parameter int MEM_AW = `FAL_MEM_AW,
   parameter int RWL_CYC = `FAL_RWL_CYC,
   parameter int PROG_CYC = `FAL_PROG_CYC,
   parameter int ERASEP_CYC = `FAL_ERASE_PARAM_CYC,
   parameter int ERASEM_CYC = `FAL_ERASE_MAIN_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Link pins
   fal_link_if.dev link,
   // Configuration bit access
   input wire logic cfg_clr,
   output logic cfg_bit_four,
   // Program and erase command
   input wire fal_pkg::fal_pe_cmd_e pe_cmd,
   input wire logic [MEM_AW-1:0] pe_addr,
   input wire logic [`FAL_DATA_W-1:0] pe_data,
   output logic pe_busy,
   // Status
   output logic seq_done,
   output logic [MEM_AW-1:0] start_addr
);
   import fal_pkg::*;

   localparam int DW = `FAL_DATA_W;
   localparam int TW = `FAL_TIMER_W;
   localparam int DEPTH = 1 << MEM_AW;
   localparam logic [1:0] CAPTURE_EDGE = 2'(`FAL_FIRST_CAPTURE_EDGE);
   localparam logic [1:0] LAST_EDGE = 2'(`FAL_LAST_SEQ_EDGE);
   localparam logic [15:0] RWL_LAST = 16'(RWL_CYC - 1);

   fal_dev_state_e state;           // Sequencer state
   logic por_phase;                 // Still in the first power-on pass
   logic [15:0] rwl_cnt;            // Handshake release delay counter
   logic [1:0] edge_cnt;            // Flash rising edges seen in sequence
   logic fclk_q;                    // Previous flash clock sample
   logic fclk_rise;                 // One-cycle flash clock rising edge
   logic in_reset;                  // Device reset from either source
   logic start_ok;                  // Pin levels that allow a start
   logic [MEM_AW-1:0] rd_ptr;       // Burst read pointer
   logic [DW-1:0] mem [DEPTH];      // Stored words
   logic [TW-1:0] pe_timer;         // Program or erase time left
   fal_pe_cmd_e pe_op;              // Operation in progress
   logic [MEM_AW-1:0] pe_addr_q;    // Target word or block
   logic [DW-1:0] pe_data_q;        // Word to program

   assign fclk_rise = link.fclk & ~fclk_q;
   assign in_reset = srst | ~link.hw_reset_n;
   // Start needs strobe high, reset high and enable low together
   assign start_ok = link.adv_n & link.hw_reset_n & ~link.oe_n;

   // Flash clock edge history
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         fclk_q <= 1'b0;
      end else begin
         fclk_q <= link.fclk;
      end
   end

   // Power-on flag, cleared by the first finished sequence only
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         por_phase <= 1'b1;
      end else if (state == FAL_D_SEQ && fclk_rise && edge_cnt == LAST_EDGE) begin
         por_phase <= 1'b0;
      end
   end

   // Sequencer: hold, arm, count edges, burst
   always_ff @(posedge ref_clk) begin
      if (in_reset) begin
         // Handshake kept low while reset lasts
         state <= FAL_D_HOLD;
         rwl_cnt <= 16'h0000;
         edge_cnt <= 2'b00;
         link.ready_wait <= 1'b0;
         seq_done <= 1'b0;
      end else begin
         unique case (state)
            FAL_D_HOLD: begin
               // Release only after the settle delay
               if (rwl_cnt == RWL_LAST) begin
                  link.ready_wait <= 1'b1;
                  state <= FAL_D_ARM;
               end else begin
                  rwl_cnt <= rwl_cnt + 16'h0001;
               end
            end
            FAL_D_ARM: begin
               edge_cnt <= 2'b00;
               if (por_phase) begin
                  // Power-on: wait for enable low after release
                  if (start_ok) begin
                     state <= FAL_D_SEQ;
                  end
               end else if (start_ok) begin
                  // Later passes: only the rise just seen counts
                  state <= FAL_D_SEQ;
               end else begin
                  // Missed the rise; enable changes do not restart
                  state <= FAL_D_BURST;
                  seq_done <= 1'b0;
               end
            end
            FAL_D_SEQ: begin
               if (fclk_rise) begin
                  edge_cnt <= edge_cnt + 2'b01;
                  // Fourth edge closes the sequence
                  if (edge_cnt == LAST_EDGE) begin
                     state <= FAL_D_BURST;
                     seq_done <= 1'b1;
                  end
               end
            end
            FAL_D_BURST: begin
               state <= FAL_D_BURST;
            end
         endcase
      end
   end

   // Start address captured on the third edge
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         start_addr <= '0;
      end else if (state == FAL_D_SEQ && fclk_rise && edge_cnt == CAPTURE_EDGE) begin
         start_addr <= link.addr[MEM_AW-1:0];
      end
   end

   // Burst pointer and data, advanced per edge while enabled
   always_ff @(posedge ref_clk) begin
      if (in_reset) begin
         rd_ptr <= '0;
         link.data <= '0;
      end else if (state == FAL_D_SEQ && fclk_rise && edge_cnt == LAST_EDGE) begin
         rd_ptr <= start_addr;
         link.data <= mem[start_addr];
      end else if (state == FAL_D_BURST && seq_done && fclk_rise && !link.oe_n) begin
         rd_ptr <= rd_ptr + 1'b1;
         link.data <= mem[MEM_AW'(rd_ptr + 1'b1)];
      end
   end

   // Config bit four: set by handshake low, set wins over clear
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cfg_bit_four <= 1'b1;
      end else if (in_reset || !link.ready_wait) begin
         cfg_bit_four <= 1'b1;
      end else if (cfg_clr) begin
         cfg_bit_four <= 1'b0;
      end
   end

   // Program and erase timer; work lands when the maximum time ends
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pe_busy <= 1'b0;
         pe_timer <= '0;
         pe_op <= FAL_PE_NONE;
         pe_addr_q <= '0;
         pe_data_q <= '0;
      end else if (!pe_busy) begin
         if (pe_cmd != FAL_PE_NONE) begin
            pe_busy <= 1'b1;
            pe_op <= pe_cmd;
            pe_addr_q <= pe_addr;
            pe_data_q <= pe_data;
            unique case (pe_cmd)
               FAL_PE_PROG: pe_timer <= TW'(PROG_CYC - 1);
               FAL_PE_ERASEP: pe_timer <= TW'(ERASEP_CYC - 1);
               FAL_PE_ERASEM: pe_timer <= TW'(ERASEM_CYC - 1);
               default: pe_timer <= '0;
            endcase
         end
      end else if (pe_timer == '0) begin
         pe_busy <= 1'b0;
         pe_op <= FAL_PE_NONE;
      end else begin
         pe_timer <= pe_timer - 1'b1;
      end
   end

   // Array update: program clears bits, erase fills the block with ones
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= {DW{1'b1}};
         end
      end else if (pe_busy && pe_timer == '0) begin
         if (pe_op == FAL_PE_PROG) begin
            mem[pe_addr_q] <= mem[pe_addr_q] & pe_data_q;
         end else begin
            // Block is the top bit of the index; one erase per half
            for (int i = 0; i < DEPTH; i++) begin
               if (i[MEM_AW-1] == pe_addr_q[MEM_AW-1]) begin
                  mem[i] <= {DW{1'b1}};
               end
            end
         end
      end
   end
endmodule : fal_device

// >>> fal_host.sv
// Master end: resets the device, waits for the handshake, clocks the
// capture sequence and reads the burst.
// Assumes the device drives ready_wait and data synchronous to ref_clk.
`timescale 1ns/1ps
`include "fal_defines.svh"
module fal_host #(
   parameter int AW = `FAL_ADDR_W,
   parameter int DIV_HALF = 2,
   parameter bit FREE_RUN = 1'b0,
   parameter int GAP_CYC = `FAL_CLK_GAP_CYC + 8,
   parameter int RST_HOLD_CYC = `FAL_FREE_SETUP_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Link pins
   fal_link_if.host link,
   // User side
   input wire logic boot_req,
   input wire logic [AW-1:0] boot_addr,
   input wire logic supply_drop,
   input wire logic stop_req,
   output logic [`FAL_DATA_W-1:0] rd_data,
   output logic rd_valid,
   output logic booting
);
   import fal_pkg::*;

   localparam logic [7:0] DIV_LAST = 8'(DIV_HALF - 1);
   localparam logic [15:0] GAP_LAST = 16'(GAP_CYC - 1);
   localparam logic [15:0] RST_LAST = 16'(RST_HOLD_CYC - 1);
   localparam logic [1:0] LAST_EDGE = 2'(`FAL_LAST_SEQ_EDGE);

   fal_host_state_e state;     // Master state
   logic [7:0] div_cnt;        // Clock divider
   logic div_en;               // Half-period enable pulse
   logic run;                  // Clock allowed to toggle
   logic rise;                 // Master makes a rising edge now
   logic [15:0] wait_cnt;      // Reset hold and gap counter
   logic [1:0] edge_cnt;       // Rising edges in the sequence

   assign div_en = (div_cnt == DIV_LAST);
   // Stopped clock only toggles once the gap has passed
   assign run = FREE_RUN || state == FAL_H_SEQ || state == FAL_H_BURST;
   assign rise = div_en & run & ~link.fclk;

   // Divider for the flash clock
   always_ff @(posedge ref_clk) begin
      if (srst || div_en) begin
         div_cnt <= 8'h00;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end

   // Flash clock, parked low when not running
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         link.fclk <= 1'b0;
      end else if (!run) begin
         link.fclk <= 1'b0;
      end else if (div_en) begin
         link.fclk <= ~link.fclk;
      end
   end

   // Master sequencer
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state <= FAL_H_IDLE;
         wait_cnt <= 16'h0000;
         edge_cnt <= 2'b00;
         link.hw_reset_n <= 1'b1;
         link.oe_n <= 1'b1;
         link.adv_n <= 1'b1;
         link.addr <= '0;
         booting <= 1'b0;
      end else if (supply_drop) begin
         // Supply dip: device output untrusted until reset again
         state <= FAL_H_RST;
         wait_cnt <= 16'h0000;
         link.hw_reset_n <= 1'b0;
         booting <= 1'b1;
      end else begin
         unique case (state)
            FAL_H_IDLE: begin
               if (boot_req) begin
                  state <= FAL_H_RST;
                  wait_cnt <= 16'h0000;
                  link.addr <= boot_addr;
                  link.hw_reset_n <= 1'b0;
                  booting <= 1'b1;
               end
            end
            FAL_H_RST: begin
               // Address and enable settle long before release
               link.oe_n <= 1'b0;
               link.adv_n <= 1'b1;
               if (wait_cnt == RST_LAST) begin
                  link.hw_reset_n <= 1'b1;
                  state <= FAL_H_WAITRW;
               end else begin
                  wait_cnt <= wait_cnt + 16'h0001;
               end
            end
            FAL_H_WAITRW: begin
               wait_cnt <= 16'h0000;
               if (link.ready_wait) begin
                  state <= FAL_H_GAP;
               end
            end
            FAL_H_GAP: begin
               // Enable fell earlier, so one gap covers both waits
               if (wait_cnt == GAP_LAST) begin
                  state <= FAL_H_SEQ;
                  edge_cnt <= 2'b00;
               end else begin
                  wait_cnt <= wait_cnt + 16'h0001;
               end
            end
            FAL_H_SEQ: begin
               if (rise) begin
                  edge_cnt <= edge_cnt + 2'b01;
                  if (edge_cnt == LAST_EDGE) begin
                     state <= FAL_H_BURST;
                     booting <= 1'b0;
                  end
               end
            end
            FAL_H_BURST: begin
               // Address is never moved, so it outlasts the hold time
               if (stop_req) begin
                  state <= FAL_H_IDLE;
                  link.oe_n <= 1'b1;
               end
            end
         endcase
      end
   end

   // Burst read: word sampled as each new edge is made
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rd_data <= '0;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= (state == FAL_H_BURST) && rise && !supply_drop;
         if (state == FAL_H_BURST && rise) begin
            rd_data <= link.data;
         end
      end
   end
endmodule : fal_host

// >>> fal_link_asserts.sv
// Checker for the pins between the flash device end and the master end.
// Assumes one ref_clk domain and a flash clock that is not free running.
`timescale 1ns/1ps
`include "fal_defines.svh"
module fal_link_asserts #(
   parameter int GAP_MIN = `FAL_CLK_GAP_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Link pins
   input wire logic fclk,
   input wire logic [22:0] addr,
   input wire logic [15:0] data,
   input wire logic oe_n,
   input wire logic adv_n,
   input wire logic hw_reset_n,
   input wire logic ready_wait
);
   logic fclk_q; // Last flash clock sample
   logic rise_d1; // Rise seen one cycle back
   logic rise_d2; // Rise seen two cycles back
   logic [5:0] rw_cnt; // Cycles since handshake release
   logic [2:0] k_cnt; // Flash clock rises since release
   wire logic k_rise = fclk & ~fclk_q; // Same rise test as the device

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   // Rise history, cleared by reset so no stale rise leaks out
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         fclk_q <= 1'b0;
         rise_d1 <= 1'b0;
         rise_d2 <= 1'b0;
      end else begin
         fclk_q <= fclk;
         rise_d1 <= k_rise;
         rise_d2 <= rise_d1;
      end
   end

   // Release age, saturating so it never wraps back under the gap
   always_ff @(posedge ref_clk) begin
      if (srst || !ready_wait) rw_cnt <= 6'h00;
      else if (rw_cnt != 6'h3f) rw_cnt <= rw_cnt + 6'h01;
   end

   // Rise count of the capture sequence
   always_ff @(posedge ref_clk) begin
      if (srst || !ready_wait) k_cnt <= 3'h0;
      else if (k_rise && k_cnt != 3'h7) k_cnt <= k_cnt + 3'h1;
   end

   AST_GAP_AFTER_RELEASE: assert property (
      (ready_wait && rw_cnt < GAP_MIN) |-> !fclk) else $error("flash clock inside gap");
   AST_START_PINS: assert property (
      (k_rise && k_cnt < 3'h4) |-> (adv_n && hw_reset_n && !oe_n))
      else $error("start pins wrong at rise");
   AST_FOUR_CYCLES: assert property (
      (k_rise && k_cnt < 3'h3) |-> ##4 (k_rise || !ready_wait))
      else $error("capture rises not spaced");
   AST_RELEASE_DELAY: assert property (
      $rose(hw_reset_n) |=> !ready_wait [*3] ##[1:6] ready_wait)
      else $error("handshake release timing");
   AST_LOW_IN_RESET: assert property (
      !hw_reset_n |=> !ready_wait) else $error("handshake high during reset");
   AST_FALL_ONLY_RESET: assert property (
      $fell(ready_wait) |-> (!$past(hw_reset_n) || !$past(hw_reset_n, 2)))
      else $error("handshake fell without reset");
   AST_DATA_STANDS: assert property (
      $changed(data) |-> (rise_d1 || rise_d2 || !$past(hw_reset_n)))
      else $error("data moved without clock rise");
   AST_CLOCK_STILL: assert property (
      (!ready_wait && !$past(ready_wait) && !$past(ready_wait, 2)) |-> !fclk)
      else $error("flash clock while held");
   AST_ADDR_HOLD: assert property (
      (ready_wait && hw_reset_n) |-> $stable(addr)) else $error("address moved");
endmodule : fal_link_asserts

// >>> fal_link_if.sv
// Pin bundle between the flash device end and the configuration master.
// Assumes both ends run on the same ref_clk; pins are plain one-way wires.
`timescale 1ns/1ps
`include "fal_defines.svh"
interface fal_link_if #(
   parameter int AW = `FAL_ADDR_W,
   parameter int DW = `FAL_DATA_W
);
   logic fclk;            // Flash clock made by the master
   logic [AW-1:0] addr;   // Read address from the master
   logic [DW-1:0] data;   // Read data from the device
   logic oe_n;            // Output enable, active low
   logic adv_n;           // Address strobe, active low
   logic hw_reset_n;      // Hardware reset, active low
   logic ready_wait;      // Handshake, driven by the device
   modport dev (input fclk, addr, oe_n, adv_n, hw_reset_n, output data, ready_wait);
   modport host (output fclk, addr, oe_n, adv_n, hw_reset_n, input data, ready_wait);
endinterface : fal_link_if

// >>> fal_pkg.sv
// Types shared by both ends of the first-address capture link.
// Assumes fal_defines.svh supplies all numeric constants.
package fal_pkg;
   // Device sequencer states
   typedef enum logic [3:0] {
      FAL_D_HOLD  = 4'b0001,
      FAL_D_ARM   = 4'b0010,
      FAL_D_SEQ   = 4'b0100,
      FAL_D_BURST = 4'b1000
   } fal_dev_state_e;
   // Host sequencer states
   typedef enum logic [5:0] {
      FAL_H_IDLE   = 6'b00_0001,
      FAL_H_RST    = 6'b00_0010,
      FAL_H_WAITRW = 6'b00_0100,
      FAL_H_GAP    = 6'b00_1000,
      FAL_H_SEQ    = 6'b01_0000,
      FAL_H_BURST  = 6'b10_0000
   } fal_host_state_e;
   // Program and erase commands on the device user side
   typedef enum logic [1:0] {
      FAL_PE_NONE   = 2'b00,
      FAL_PE_PROG   = 2'b01,
      FAL_PE_ERASEP = 2'b10,
      FAL_PE_ERASEM = 2'b11
   } fal_pe_cmd_e;
endpackage : fal_pkg

// >>> first_address_latch_startup_tb_top.sv
// Bench joining the device end and master end over the link interface.
// Assumes shortened program, erase and reset counts set at the instances.
`timescale 1ns/1ps
`include "fal_defines.svh"
module first_address_latch_startup_tb_top;
   import fal_pkg::*;
   typedef struct {fal_pe_cmd_e cmd; logic [7:0] a; logic [15:0] d; int n;} fal_tb_row_s;
   logic ref_clk = 1'b0; // 40 MHz reference
   logic srst = 1'b1; // Held for two cycles at start
   logic cfg_clr = 1'b0;
   logic boot_req = 1'b0;
   logic supply_drop = 1'b0;
   logic stop_req = 1'b0;
   fal_pe_cmd_e pe_cmd = FAL_PE_NONE;
   logic [7:0] pe_addr = 8'h00;
   logic [15:0] pe_data = 16'h0000;
   logic [22:0] boot_addr = 23'h00_0000;
   logic cfg_bit_four, pe_busy, seq_done, booting, rd_valid;
   logic [7:0] start_addr;
   logic [15:0] rd_data;
   int err_count = 0;
   int n_compared = 0;
   int cyc = 0; // Timeout counter
   // Program, erase and a refused command in the main erase row
   fal_tb_row_s rows[7] = '{'{FAL_PE_PROG, 8'h05, 16'h0000, 10},
      '{FAL_PE_ERASEP, 8'h10, 16'h0000, 20}, '{FAL_PE_PROG, 8'h05, 16'h1234, 10},
      '{FAL_PE_PROG, 8'h06, 16'hABCD, 10}, '{FAL_PE_PROG, 8'h06, 16'h0F0F, 10},
      '{FAL_PE_ERASEM, 8'h90, 16'h0000, 30}, '{FAL_PE_PROG, 8'h07, 16'h5A5A, 10}};
   logic [15:0] burst_exp[4] = '{16'h1234, 16'h0B0D, 16'h5A5A, 16'hFFFF};

   fal_link_if fal_link_if_inst ();
   fal_device #(.RWL_CYC(4), .PROG_CYC(10), .ERASEP_CYC(20), .ERASEM_CYC(30))
   fal_device_inst (.ref_clk(ref_clk), .srst(srst), .link(fal_link_if_inst),
      .cfg_clr(cfg_clr), .cfg_bit_four(cfg_bit_four), .pe_cmd(pe_cmd), .pe_addr(pe_addr),
      .pe_data(pe_data), .pe_busy(pe_busy), .seq_done(seq_done), .start_addr(start_addr));
   fal_host #(.RST_HOLD_CYC(16)) fal_host_inst (.ref_clk(ref_clk), .srst(srst),
      .link(fal_link_if_inst), .boot_req(boot_req), .boot_addr(boot_addr),
      .supply_drop(supply_drop), .stop_req(stop_req), .rd_data(rd_data),
      .rd_valid(rd_valid), .booting(booting));
   fal_link_asserts fal_link_asserts_inst (.ref_clk(ref_clk), .srst(srst),
      .fclk(fal_link_if_inst.fclk), .addr(fal_link_if_inst.addr),
      .data(fal_link_if_inst.data), .oe_n(fal_link_if_inst.oe_n),
      .adv_n(fal_link_if_inst.adv_n), .hw_reset_n(fal_link_if_inst.hw_reset_n),
      .ready_wait(fal_link_if_inst.ready_wait));

   // Clock and hang guard
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end

   // Flag compare
   task automatic chk1(input logic got, input logic exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %b", $time, what, got);
      end
   endtask : chk1
   // Word compare
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %h", $time, what, got);
      end
   endtask : chk16
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : tick
   // Bounded wait; the final level is itself a comparison
   task automatic wait_lvl(ref logic s, input logic lvl, input string what);
      for (int i = 0; i < 3000 && s !== lvl; i++) tick(1);
      chk1(s, lvl, what);
   endtask : wait_lvl
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask : pulse
   // Reset, then the handshake, config bit and status reset values
   task automatic reset_chk;
      srst = 1'b1;
      tick(2);
      srst = 1'b0;
      chk1(fal_link_if_inst.ready_wait, 1'b0, "handshake in reset");
      chk1(cfg_bit_four, 1'b1, "config bit after reset");
      chk1(seq_done | pe_busy | booting, 1'b0, "status after reset");
      $display("test reset done");
   endtask : reset_chk
   task automatic close_out;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out

   initial begin
      int first, rises, got;
      logic prev;
      reset_chk();
      // Program and erase rows, back to back, one refused while busy
      foreach (rows[i]) begin
         pe_cmd = rows[i].cmd;
         pe_addr = rows[i].a;
         pe_data = rows[i].d;
         tick(1);
         for (int j = 0; j < rows[i].n; j++) begin
            pe_cmd = (i == 5 && j == 2) ? FAL_PE_PROG : FAL_PE_NONE;
            pe_addr = 8'h08;
            chk1(pe_busy, 1'b1, "busy during operation");
            tick(1);
         end
         chk1(pe_busy, 1'b0, "busy after operation");
      end
      $display("test program erase done");
      // Power-on boot from word 5, counting rises on the wire
      boot_addr = 23'h00_0005;
      pulse(boot_req);
      // Handshake is still high from the earlier release; wait for the hold first
      wait_lvl(fal_link_if_inst.ready_wait, 1'b0, "handshake held");
      wait_lvl(fal_link_if_inst.ready_wait, 1'b1, "handshake release");
      chk1(booting, 1'b1, "booting during start");
      first = -1;
      rises = 0;
      prev = 1'b0;
      for (int k = 0; k < 400 && seq_done !== 1'b1; k++) begin
         if (fal_link_if_inst.fclk && !prev) rises++;
         if (fal_link_if_inst.fclk && first < 0) first = k;
         prev = fal_link_if_inst.fclk;
         tick(1);
      end
      chk1(first >= `FAL_CLK_GAP_CYC, 1'b1, "clock gap");
      chk16(16'(rises), 16'd4, "rises to done");
      chk16({8'h00, start_addr}, 16'h0005, "latched start");
      chk1(booting, 1'b0, "booting after fourth rise");
      got = 0;
      for (int k = 0; k < 200 && got < 4; k++) begin
         tick(1);
         if (rd_valid === 1'b1) begin
            chk16(rd_data, burst_exp[got], "burst word");
            got++;
         end
      end
      chk16(16'(got), 16'd4, "burst count");
      pulse(stop_req);
      $display("test boot done");
      // Second boot from word 6, aborted by a supply drop mid-sequence
      boot_addr = 23'h00_0006;
      pulse(boot_req);
      wait_lvl(fal_link_if_inst.ready_wait, 1'b0, "handshake low");
      wait_lvl(fal_link_if_inst.ready_wait, 1'b1, "handshake release");
      pulse(cfg_clr);
      chk1(cfg_bit_four, 1'b0, "config bit cleared");
      wait_lvl(fal_link_if_inst.fclk, 1'b1, "first rise");
      pulse(supply_drop);
      wait_lvl(fal_link_if_inst.ready_wait, 1'b0, "abort handshake");
      tick(1);
      chk1(cfg_bit_four, 1'b1, "config bit on abort");
      chk1(seq_done, 1'b0, "sequence abandoned");
      wait_lvl(seq_done, 1'b1, "restart done");
      chk16({8'h00, start_addr}, 16'h0006, "restart start");
      $display("test abort done");
      reset_chk();
      close_out();
   end
endmodule : first_address_latch_startup_tb_top
